// ==== hw/nadc_top.sv ====
// nibble alu with status word, system nibble, register bank and data memory over apb
// assumes an apb master on the same 40 MHz clock; no interrupts, no buffering
// Function
// - compare-only with binary mode: compute add/sub but never write back
// - compare-only: carry set on carry or borrow, else cleared
// - compare-only: zero kept on 0000, cleared on nonzero result
// - decimal write-back: carry set when result above nine or below zero
// - decimal write-back: zero set when stored result is 0000
// - decimal result is binary result passed with carry through adjustment
// - out-of-range decimal sets carry, nibble may be ten or more
// - compare-only plus decimal: decimal flags, no write-back
// - arithmetic into status word without compare-only stores the result over flags
// - status word target with compare-only: not stored, flags update normally
// - decimal flag lives in bit zero of a separate system nibble
// - status word: compare-only bit 3, carry bit 2, zero bit 1
// - logic ops ignore mode flags, always write, leave carry and zero unless the status word is the target
// - index enable adds index register to logic memory operand address
// - forms: register with memory, or memory with immediate; result to first
// - binary write-back: carry on overflow or borrow, zero only for 0000
// - carrying variants use carry flag and reload it
module nadc_top #(
  parameter int MEM_DEPTH = 16,
  parameter int MEM_AW = 4
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // visible state
  output logic [3:0] status_word_out,
  output logic busy_out
);
  typedef enum logic [1:0] {NADC_IDLE, NADC_READ, NADC_EXEC} nadc_st_e;
  nadc_st_e st_r;
  logic [3:0] status_word_r;
  logic [3:0] sys_r;
  logic [3:0] res_r;
  logic [3:0] gr_r [16];
  logic [3:0] idx_r;
  logic [2:0] op_r;
  logic form_r;
  logic sw_tgt_r;
  logic idx_en_r;
  logic [3:0] rsel_r;
  logic [MEM_AW-1:0] maddr_r;
  logic [3:0] imm_r;
  logic [MEM_AW-1:0] eff_addr;
  logic mem_we;
  logic [3:0] mem_rd;
  logic [3:0] a_val;
  logic [3:0] b_val;
  logic wb_en;
  logic acc;
  logic wr;
  logic [3:0] wdata;
  logic [31:0] rd_nxt;
  logic rd_err;
  nadc_if alu ();
  nadc_core u_core (
    .alu(alu)
  );
  assign acc = psel_in && penable_in && pready_out;
  assign wr = acc && pwrite_in;
  assign wdata = pwdata_in[3:0];
  // index modifies the memory address for logic operations
  always_comb begin
    eff_addr = maddr_r;
    if (idx_en_r && (op_r >= 3'(nadc_pkg::NADC_OR))) begin
      eff_addr = maddr_r + MEM_AW'(idx_r);
    end
  end
  // form 0: register with memory; form 1: memory with immediate
  always_comb begin
    if (form_r) begin
      a_val = mem_rd;
      b_val = imm_r;
    end else begin
      a_val = gr_r[rsel_r];
      b_val = mem_rd;
    end
    if (sw_tgt_r) begin
      a_val = status_word_r;
    end
  end
  assign alu.op = op_r;
  assign alu.a = a_val;
  assign alu.b = b_val;
  assign alu.cy_in = status_word_r[nadc_pkg::NADC_SW_CY];
  assign alu.dec = sys_r[nadc_pkg::NADC_SYS_DEC];
  // logic ops always write; arithmetic writes only with compare-only clear
  assign wb_en = !alu.is_arith || !status_word_r[nadc_pkg::NADC_SW_CMP];
  assign mem_we = (st_r == NADC_EXEC) && wb_en && form_r && !sw_tgt_r;
  nadc_mem #(
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_mem (
    .clock_in(clock_in),
    .we_in(mem_we),
    .waddr_in(eff_addr),
    .wdata_in(alu.res),
    .raddr_in(eff_addr),
    .rdata_out(mem_rd)
  );
  // sequencer: one cycle for the registered memory read, one to execute
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      st_r <= NADC_IDLE;
    end else begin
      case (st_r)
        NADC_IDLE: begin
          if (wr && (paddr_in == nadc_pkg::NADC_A_CMD)) begin
            st_r <= NADC_READ;
          end
        end
        NADC_READ: st_r <= NADC_EXEC;
        NADC_EXEC: st_r <= NADC_IDLE;
        default: st_r <= NADC_IDLE;
      endcase
    end
  end
  // command word: op, form, status target, register select, memory address, immediate
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      op_r <= 3'h0;
      form_r <= 1'b0;
      sw_tgt_r <= 1'b0;
      rsel_r <= 4'h0;
      maddr_r <= '0;
      imm_r <= 4'h0;
    end else if (wr && (paddr_in == nadc_pkg::NADC_A_CMD) && (st_r == NADC_IDLE)) begin
      op_r <= pwdata_in[2:0];
      form_r <= pwdata_in[3];
      sw_tgt_r <= pwdata_in[4];
      rsel_r <= pwdata_in[11:8];
      maddr_r <= pwdata_in[12 +: MEM_AW];
      imm_r <= pwdata_in[23:20];
    end
  end
  // status word: hardware flag update wins over software write in execute cycle
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      status_word_r <= nadc_pkg::NADC_SW_RST;
    end else if ((st_r == NADC_EXEC) && alu.is_arith) begin
      if (sw_tgt_r && wb_en) begin
        status_word_r <= alu.res;
      end else begin
        status_word_r[nadc_pkg::NADC_SW_CY] <= alu.cy_out;
        if (status_word_r[nadc_pkg::NADC_SW_CMP]) begin
          if (!alu.is_zero) begin
            status_word_r[nadc_pkg::NADC_SW_Z] <= 1'b0;
          end
        end else begin
          status_word_r[nadc_pkg::NADC_SW_Z] <= alu.is_zero;
        end
      end
    end else if ((st_r == NADC_EXEC) && sw_tgt_r) begin
      status_word_r <= alu.res;
    end else if (wr && (paddr_in == nadc_pkg::NADC_A_SW)) begin
      status_word_r <= wdata;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      sys_r <= nadc_pkg::NADC_SYS_RST;
      idx_r <= 4'h0;
      idx_en_r <= 1'b0;
    end else begin
      if (wr && (paddr_in == nadc_pkg::NADC_A_SYS)) begin
        sys_r <= wdata;
      end
      if (wr && (paddr_in == nadc_pkg::NADC_A_IDX)) begin
        idx_r <= wdata;
        idx_en_r <= pwdata_in[8];
      end
    end
  end
  // general register bank written by apb or by register-form results
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 16; i++) begin
        gr_r[i] <= 4'h0;
      end
    end else if ((st_r == NADC_EXEC) && wb_en && !form_r && !sw_tgt_r) begin
      gr_r[rsel_r] <= alu.res;
    end else if (wr && (paddr_in[7:6] == 2'h1)) begin
      gr_r[paddr_in[5:2]] <= wdata;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      res_r <= 4'h0;
    end else if (st_r == NADC_EXEC) begin
      res_r <= alu.res;
    end
  end
  // apb read mux; unmapped addresses answer with slverr
  always_comb begin
    rd_nxt = 32'h0;
    rd_err = 1'b0;
    if (paddr_in[7:6] == 2'h1) begin
      rd_nxt = {28'h0, gr_r[paddr_in[5:2]]};
    end else begin
      case (paddr_in)
        nadc_pkg::NADC_A_CMD: rd_nxt = {31'h0, st_r != NADC_IDLE};
        nadc_pkg::NADC_A_OPS: rd_nxt = {28'h0, mem_rd};
        nadc_pkg::NADC_A_SW: rd_nxt = {28'h0, status_word_r};
        nadc_pkg::NADC_A_SYS: rd_nxt = {28'h0, sys_r};
        nadc_pkg::NADC_A_RES: rd_nxt = {28'h0, res_r};
        nadc_pkg::NADC_A_IDX: rd_nxt = {23'h0, idx_en_r, 4'h0, idx_r};
        default: rd_err = 1'b1;
      endcase
    end
  end
  // pready is registered: every access takes exactly one wait state
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      if (psel_in && penable_in && !pready_out) begin
        prdata_out <= pwrite_in ? 32'h0 : rd_nxt;
        pslverr_out <= rd_err;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      status_word_out <= nadc_pkg::NADC_SW_RST;
      busy_out <= 1'b0;
    end else begin
      status_word_out <= status_word_r;
      busy_out <= (st_r == NADC_IDLE) ? (wr && (paddr_in == nadc_pkg::NADC_A_CMD))
                                      : (st_r == NADC_READ);
    end
  end
  chk_cmp_no_wb: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && alu.is_arith && status_word_r[3] && !form_r && !sw_tgt_r)
    |=> gr_r[$past(rsel_r)] == $past(gr_r[rsel_r]))
    else $error("compare-only wrote back");
  chk_cmp_zero_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && alu.is_arith && status_word_r[3] && !sw_tgt_r)
    |=> status_word_r[1] == ($past(status_word_r[1]) && $past(alu.is_zero)))
    else $error("compare zero not accumulated");
  chk_carry_upd: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && alu.is_arith && !(sw_tgt_r && wb_en))
    |=> status_word_r[2] == $past(alu.cy_out))
    else $error("carry flag not updated");
  chk_dec_range: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && alu.is_arith && sys_r[0] && alu.res > 4'h9) |-> alu.cy_out)
    else $error("decimal overflow without carry");
  chk_bin_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && alu.is_arith && !status_word_r[3] && !sw_tgt_r)
    |=> status_word_r[1] == $past(alu.is_zero))
    else $error("zero flag wrong");
  chk_sw_target: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && sw_tgt_r && wb_en) |=> status_word_r == $past(alu.res))
    else $error("status word target not stored");
  chk_logic_flags: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && !alu.is_arith && !sw_tgt_r) |=> $stable(status_word_r[2:1]))
    else $error("logic op touched flags");
  chk_plain_nocy: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && op_r == 3'(nadc_pkg::NADC_ADD) && !sys_r[0])
    |-> alu.res == 4'(a_val + b_val))
    else $error("plain add used carry");
  chk_seq_len: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_READ) |=> (st_r == NADC_EXEC) ##1 (st_r == NADC_IDLE))
    else $error("sequence length wrong");
  cov_cmp_chain: cover property (@(posedge clock_in) disable iff (!resetn_in)
    st_r == NADC_EXEC && status_word_r[3] && alu.is_arith);
  cov_dec_carry: cover property (@(posedge clock_in) disable iff (!resetn_in)
    st_r == NADC_EXEC && sys_r[0] && alu.cy_out);
  cov_logic_idx: cover property (@(posedge clock_in) disable iff (!resetn_in)
    st_r == NADC_EXEC && !alu.is_arith && idx_en_r);
  cov_sw_target: cover property (@(posedge clock_in) disable iff (!resetn_in)
    st_r == NADC_EXEC && sw_tgt_r && alu.is_arith);
  cov_dec_cmp: cover property (@(posedge clock_in) disable iff (!resetn_in)
    st_r == NADC_EXEC && sys_r[0] && status_word_r[3] && alu.is_arith);
  // reference sums built from the operands, not from the core's adjust path
  logic [4:0] dsum_chk;
  assign dsum_chk = {1'b0, a_val} + {1'b0, b_val};
  chk_dec_add_ok: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && sys_r[0] && op_r == 3'(nadc_pkg::NADC_ADD) && dsum_chk <= 5'h13)
    |-> alu.cy_out == (dsum_chk > 5'h09)
        && alu.res == 4'((dsum_chk > 5'h09) ? dsum_chk - 5'h0A : dsum_chk))
    else $error("decimal add wrong");
  // only differences from minus ten to nine have a defined decimal result
  chk_dec_sub_ok: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && sys_r[0] && op_r == 3'(nadc_pkg::NADC_SUB)
      && {1'b0, a_val} <= {1'b0, b_val} + 5'h09 && {1'b0, b_val} <= {1'b0, a_val} + 5'h0A)
    |-> alu.cy_out == (a_val < b_val)
        && alu.res == ((a_val < b_val) ? 4'(a_val - b_val + nadc_pkg::NADC_TEN)
                                        : 4'(a_val - b_val)))
    else $error("decimal subtract wrong");
  // binary results compared as one five-bit value, carry on top
  chk_bin_add_ok: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && !sys_r[0] && op_r == 3'(nadc_pkg::NADC_ADD))
    |-> {alu.cy_out, alu.res} == dsum_chk)
    else $error("binary add wrong");
  chk_bin_sub_ok: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && !sys_r[0] && op_r == 3'(nadc_pkg::NADC_SUB))
    |-> {alu.cy_out, alu.res} == {1'b0, a_val} - {1'b0, b_val})
    else $error("binary subtract wrong");
  chk_add_with_carry_op_carry: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && !sys_r[0] && op_r == 3'(nadc_pkg::NADC_ADD_WITH_CARRY_OP))
    |-> {alu.cy_out, alu.res} == dsum_chk + {4'h0, status_word_r[2]})
    else $error("add with carry wrong");
  chk_subtract_with_borrow_op_borrow: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && !sys_r[0] && op_r == 3'(nadc_pkg::NADC_SUBTRACT_WITH_BORROW_OP))
    |-> {alu.cy_out, alu.res} == {1'b0, a_val} - {1'b0, b_val} - {4'h0, status_word_r[2]})
    else $error("subtract with borrow wrong");
  chk_logic_bits: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && op_r >= 3'(nadc_pkg::NADC_OR) && op_r <= 3'(nadc_pkg::NADC_XOR))
    |-> alu.res == ((op_r == 3'(nadc_pkg::NADC_OR)) ? (a_val | b_val)
        : (op_r == 3'(nadc_pkg::NADC_AND)) ? (a_val & b_val) : (a_val ^ b_val)))
    else $error("logic result wrong");
  chk_logic_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (st_r == NADC_EXEC && !alu.is_arith && !form_r && !sw_tgt_r)
    |=> gr_r[$past(rsel_r)] == $past(alu.res))
    else $error("logic result not written");
  // busy covers exactly the read and execute cycles
  chk_busy_len: assert property (@(posedge clock_in) disable iff (!resetn_in)
    $rose(busy_out) |=> busy_out ##1 !busy_out)
    else $error("busy width wrong");
  chk_sw_mirror: assert property (@(posedge clock_in) disable iff (!resetn_in)
    1'b1 |=> status_word_out == $past(status_word_r))
    else $error("status word pin out of step");
endmodule

// ==== hw/nadc_pkg.sv ====
// constants shared by the nibble alu block
// assumes a 4-bit core datapath on one 40 MHz clock
package nadc_pkg;
  localparam int NADC_W = 4;
  localparam logic [3:0] NADC_ZERO = 4'h0;
  localparam logic [3:0] NADC_NINE = 4'h9;
  localparam logic [3:0] NADC_SIX = 4'h6;
  localparam logic [3:0] NADC_TEN = 4'hA;
  // status word bit positions
  localparam int NADC_SW_CMP = 3;
  localparam int NADC_SW_CY = 2;
  localparam int NADC_SW_Z = 1;
  localparam int NADC_SW_B0 = 0;
  // system register nibble: decimal flag position
  localparam int NADC_SYS_DEC = 0;
  localparam logic [3:0] NADC_SW_RST = 4'h0;
  localparam logic [3:0] NADC_SYS_RST = 4'h0;
  // apb register map (byte addresses)
  localparam logic [7:0] NADC_A_CMD = 8'h00;
  localparam logic [7:0] NADC_A_OPS = 8'h04;
  localparam logic [7:0] NADC_A_SW = 8'h08;
  localparam logic [7:0] NADC_A_SYS = 8'h0C;
  localparam logic [7:0] NADC_A_RES = 8'h10;
  localparam logic [7:0] NADC_A_IDX = 8'h14;
  typedef enum logic [2:0] {
    NADC_ADD, NADC_ADD_WITH_CARRY_OP, NADC_SUB, NADC_SUBTRACT_WITH_BORROW_OP, NADC_OR, NADC_AND, NADC_XOR
  } nadc_op_e;
endpackage

// ==== hw/nadc_if.sv ====
// interface carrying one alu request and its answer
// assumes a single clock domain
interface nadc_if;
  logic [2:0] op;
  logic [3:0] a;
  logic [3:0] b;
  logic cy_in;
  logic dec;
  logic [3:0] res;
  logic cy_out;
  logic is_zero;
  logic is_arith;
  modport core (input op, a, b, cy_in, dec, output res, cy_out, is_zero, is_arith);
  modport user (output op, a, b, cy_in, dec, input res, cy_out, is_zero, is_arith);
endinterface

// ==== hw/nadc_core.sv ====
// combinational nibble alu: binary/decimal add/sub and bitwise logic
// assumes operands are stable while the caller samples the answer
module nadc_core (
  nadc_if.core alu
);
  logic [4:0] bin;
  logic [4:0] adj;
  logic use_cy;
  logic is_add;
  always_comb begin
    use_cy = (alu.op == nadc_pkg::NADC_ADD_WITH_CARRY_OP) || (alu.op == nadc_pkg::NADC_SUBTRACT_WITH_BORROW_OP);
    is_add = (alu.op == nadc_pkg::NADC_ADD) || (alu.op == nadc_pkg::NADC_ADD_WITH_CARRY_OP);
    if (is_add) begin
      bin = {1'b0, alu.a} + {1'b0, alu.b} + {4'h0, use_cy & alu.cy_in};
    end else begin
      bin = {1'b0, alu.a} - {1'b0, alu.b} - {4'h0, use_cy & alu.cy_in};
    end
    // decimal adjust follows the binary stage, carry included
    adj = bin;
    if (alu.dec) begin
      if (is_add) begin
        if (bin[4] || (bin[3:0] > nadc_pkg::NADC_NINE)) begin
          adj = {1'b1, bin[3:0] + nadc_pkg::NADC_SIX};
        end
      end else if (bin[4]) begin
        adj = {1'b1, bin[3:0] - nadc_pkg::NADC_SIX};
      end else if (bin[3:0] > nadc_pkg::NADC_NINE) begin
        adj = {1'b1, bin[3:0]};
      end
    end
  end
  always_comb begin
    alu.is_arith = 1'b1;
    alu.res = adj[3:0];
    alu.cy_out = adj[4];
    case (alu.op)
      nadc_pkg::NADC_OR: begin
        alu.res = alu.a | alu.b;
        alu.is_arith = 1'b0;
      end
      nadc_pkg::NADC_AND: begin
        alu.res = alu.a & alu.b;
        alu.is_arith = 1'b0;
      end
      nadc_pkg::NADC_XOR: begin
        alu.res = alu.a ^ alu.b;
        alu.is_arith = 1'b0;
      end
      default: begin
      end
    endcase
    alu.is_zero = (alu.res == nadc_pkg::NADC_ZERO);
  end
endmodule

// ==== hw/nadc_mem.sv ====
// small nibble data memory with registered read data
// assumes one write port and one read port on the core clock
module nadc_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock
  input wire logic clock_in,
  // write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [3:0] wdata_in,
  // read port
  input wire logic [AW-1:0] raddr_in,
  output logic [3:0] rdata_out
);
  logic [3:0] mem_r [DEPTH];
  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end
  always_ff @(posedge clock_in) begin
    rdata_out <= mem_r[raddr_in];
  end
endmodule

// ==== tb/nadc_decoder_model.sv ====
// apb master standing in for the core decoder that feeds the nibble alu
// assumes one clock; the bench issues one transfer at a time
module nadc_decoder_model (
  // clock
  input wire logic clock_in,
  // apb request
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  // apb answer
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0000_0000;
  end

  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge clock_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= addr;
    pwdata_out <= wd;
    @(posedge clock_in);
    penable_out <= 1'b1;
    // no latency assumed; a stuck slave is cut short by the bench watchdog
    do @(posedge clock_in); while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule

// ==== tb/tb_nibble_alu_decimal_compare.sv ====
// self-checking bench for the nibble alu with status word over apb
// assumes the decoder model as apb master and a 40 MHz clock
module tb_nibble_alu_decimal_compare;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, resetn_in, psel, penable, pwrite, pready, pslverr, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] sw_out, v, ex;
  logic err;
  int miscompares = 0;
  int compares = 0;

  nadc_top #(.MEM_DEPTH(16), .MEM_AW(4)) i_dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .status_word_out(sw_out), .busy_out(busy));
  nadc_decoder_model i_dec (.clock_in(clock_in), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk4(input string name, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_dec.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rd4(input logic [7:0] a, output logic [3:0] q);
    i_dec.xfer(1'b0, a, 32'h0000_0000, rd, err);
    q = rd[3:0];
  endtask

  function automatic logic [7:0] regad(input logic [3:0] n);
    return 8'h40 + {2'b00, n, 2'b00};
  endfunction

  // a command is complete once busy has risen and fallen again
  task automatic run(input logic [31:0] c);
    int n;
    n = 0;
    wr(nadc_pkg::NADC_A_CMD, c);
    while (busy !== 1'b1 && n < 8) begin
      @(posedge clock_in);
      n++;
    end
    chk1("cmd_start", 1'b1, busy);
    while (busy !== 1'b0 && n < 30) begin
      @(posedge clock_in);
      n++;
    end
    chk1("cmd_done", 1'b1, n < 30);
  endtask

  task automatic op_rm(input logic [2:0] op, input logic [3:0] r, input logic [3:0] m);
    run({16'h0000, m, r, 5'h00, op});
  endtask

  task automatic op_mi(input logic [2:0] op, input logic [3:0] m, input logic [3:0] imm,
      input logic tgt);
    run({8'h00, imm, 4'h0, m, 4'h0, 3'h0, tgt, 1'b1, op});
  endtask

  // logic ops only, so the flags survive loading memory
  task automatic setmem(input logic [3:0] m, input logic [3:0] d);
    op_mi(nadc_pkg::NADC_AND, m, 4'h0, 1'b0);
    op_mi(nadc_pkg::NADC_OR, m, d, 1'b0);
  endtask

  task automatic getmem(input logic [3:0] m, output logic [3:0] q);
    wr(regad(4'hF), 32'h0000_000F);
    op_rm(nadc_pkg::NADC_AND, 4'hF, m);
    rd4(regad(4'hF), q);
  endtask

  task automatic chk_sw(input logic [3:0] exp);
    rd4(nadc_pkg::NADC_A_SW, v);
    chk4("status", exp, v);
    chk4("sw_pin", exp, sw_out);
  endtask

  task automatic t_reset;
    chk4("sw_pin", 4'h0, sw_out);
    chk_sw(4'h0);
    rd4(nadc_pkg::NADC_A_SYS, v);
    chk4("sys", 4'h0, v);
    i_dec.xfer(1'b1, 8'h30, 32'h0000_000F, rd, err);
    chk1("slverr", 1'b1, err);
  endtask

  task automatic t_binary;
    wr(regad(4'h1), 32'h0000_000F);
    setmem(4'h1, 4'h1);
    op_rm(nadc_pkg::NADC_ADD, 4'h1, 4'h1);
    rd4(regad(4'h1), v);
    chk4("add_res", 4'h0, v);
    chk_sw(4'h6);
    wr(regad(4'h2), 32'h0000_0008);
    op_rm(nadc_pkg::NADC_ADD, 4'h2, 4'h1);
    rd4(regad(4'h2), v);
    chk4("add_nocy", 4'h9, v);
    chk_sw(4'h0);
    setmem(4'h3, 4'h0);
    op_mi(nadc_pkg::NADC_SUB, 4'h3, 4'h1, 1'b0);
    getmem(4'h3, v);
    chk4("sub_res", 4'hF, v);
    chk_sw(4'h4);
    wr(regad(4'h5), 32'h0000_0000);
    op_rm(nadc_pkg::NADC_SUBTRACT_WITH_BORROW_OP, 4'h5, 4'h3);
    rd4(regad(4'h5), v);
    chk4("subtract_with_borrow_op_res", 4'h0, v);
    chk_sw(4'h6);
    wr(regad(4'h3), 32'h0000_0008);
    op_mi(nadc_pkg::NADC_AND, 4'h1, 4'h0, 1'b0);
    op_rm(nadc_pkg::NADC_ADD_WITH_CARRY_OP, 4'h3, 4'h1);
    rd4(regad(4'h3), v);
    chk4("add_with_carry_op_res", 4'h9, v);
    chk_sw(4'h0);
  endtask

  task automatic t_compare;
    wr(nadc_pkg::NADC_A_SW, 32'h0000_0008);
    wr(regad(4'h1), 32'h0000_000F);
    setmem(4'h1, 4'hF);
    op_rm(nadc_pkg::NADC_ADD, 4'h1, 4'h1);
    rd4(regad(4'h1), v);
    chk4("cmp_nowb", 4'hF, v);
    rd4(nadc_pkg::NADC_A_RES, v);
    chk4("cmp_res", 4'hE, v);
    chk_sw(4'hC);
    op_rm(nadc_pkg::NADC_SUB, 4'h1, 4'h1);
    chk_sw(4'h8);
    wr(nadc_pkg::NADC_A_SW, 32'h0000_000A);
    op_rm(nadc_pkg::NADC_SUB, 4'h1, 4'h1);
    chk_sw(4'hA);
    setmem(4'h2, 4'h1);
    op_mi(nadc_pkg::NADC_SUB, 4'h2, 4'h2, 1'b0);
    chk_sw(4'hC);
    getmem(4'h2, v);
    chk4("cmp_mem", 4'h1, v);
  endtask

  // operands kept inside the decimal ranges except the add with carry of ten
  task automatic t_decimal;
    wr(nadc_pkg::NADC_A_SYS, 32'h0000_0001);
    wr(nadc_pkg::NADC_A_SW, 32'h0000_0000);
    setmem(4'h1, 4'h7);
    op_mi(nadc_pkg::NADC_ADD, 4'h1, 4'h9, 1'b0);
    getmem(4'h1, v);
    chk4("dec_add", 4'h6, v);
    chk_sw(4'h4);
    op_mi(nadc_pkg::NADC_SUB, 4'h1, 4'h7, 1'b0);
    getmem(4'h1, v);
    chk4("dec_sub", 4'h9, v);
    chk_sw(4'h4);
    op_mi(nadc_pkg::NADC_ADD, 4'h1, 4'h1, 1'b0);
    getmem(4'h1, v);
    chk4("dec_zero", 4'h0, v);
    chk_sw(4'h6);
    setmem(4'h1, 4'h9);
    op_mi(nadc_pkg::NADC_ADD_WITH_CARRY_OP, 4'h1, 4'hA, 1'b0);
    rd4(nadc_pkg::NADC_A_SW, v);
    chk1("dec_over", 1'b1, v[2]);
    wr(nadc_pkg::NADC_A_SW, 32'h0000_000A);
    setmem(4'h1, 4'h3);
    op_mi(nadc_pkg::NADC_SUB, 4'h1, 4'h3, 1'b0);
    chk_sw(4'hA);
    op_mi(nadc_pkg::NADC_ADD, 4'h1, 4'h9, 1'b0);
    chk_sw(4'hC);
    getmem(4'h1, v);
    chk4("deccmp_mem", 4'h3, v);
  endtask

  task automatic t_target;
    wr(nadc_pkg::NADC_A_SYS, 32'h0000_0000);
    wr(nadc_pkg::NADC_A_SW, 32'h0000_0006);
    op_mi(nadc_pkg::NADC_ADD, 4'h0, 4'hA, 1'b1);
    chk_sw(4'h0);
    wr(nadc_pkg::NADC_A_SW, 32'h0000_000A);
    op_mi(nadc_pkg::NADC_ADD, 4'h0, 4'h8, 1'b1);
    chk_sw(4'hC);
  endtask

  task automatic t_logic;
    logic [2:0] ops [3] = '{nadc_pkg::NADC_OR, nadc_pkg::NADC_AND, nadc_pkg::NADC_XOR};
    wr(nadc_pkg::NADC_A_SYS, 32'h0000_0001);
    wr(nadc_pkg::NADC_A_SW, 32'h0000_000A);
    foreach (ops[i]) begin
      wr(regad(4'h1), 32'h0000_000A);
      setmem(4'h1, 4'h9);
      op_rm(ops[i], 4'h1, 4'h1);
      ex = (i == 0) ? 4'hB : (i == 1) ? 4'h8 : 4'h3;
      rd4(regad(4'h1), v);
      chk4("logic_rm", ex, v);
      op_mi(ops[i], 4'h1, 4'hC, 1'b0);
      ex = (i == 0) ? 4'hD : (i == 1) ? 4'h8 : 4'h5;
      getmem(4'h1, v);
      chk4("logic_mi", ex, v);
      chk_sw(4'hA);
    end
    setmem(4'h4, 4'h0);
    setmem(4'h5, 4'h0);
    wr(nadc_pkg::NADC_A_IDX, 32'h0000_0101);
    op_mi(nadc_pkg::NADC_OR, 4'h4, 4'h6, 1'b0);
    wr(nadc_pkg::NADC_A_IDX, 32'h0000_0000);
    getmem(4'h5, v);
    chk4("idx_hit", 4'h6, v);
    getmem(4'h4, v);
    chk4("idx_skip", 4'h0, v);
  endtask

  initial begin
    resetn_in = 1'b0;
    repeat (5) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_reset();
    t_binary();
    t_compare();
    t_decimal();
    t_target();
    t_logic();
    complete_run();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (40000) @(posedge clock_in);
    miscompares++;
    complete_run();
  end
endmodule
